// File: include/arpt_pkg.sv
package arpt_pkg;

	localparam int ARPT_ADDR_W = 8;
	localparam int ARPT_DATA_W = 32;
	localparam int ARPT_CNT_W = 12;
	localparam int ARPT_IDX_W = 6;

	// register indices; byte address is four times the index
	localparam logic [ARPT_IDX_W-1:0] IDX_CTRL_STATUS = 6'h0D;
	localparam logic [ARPT_IDX_W-1:0] IDX_COUNT_HIGH = 6'h0E;
	localparam logic [ARPT_IDX_W-1:0] IDX_COUNT_LOW = 6'h0F;
	localparam logic [ARPT_IDX_W-1:0] IDX_RELOAD_HIGH = 6'h10;
	localparam logic [ARPT_IDX_W-1:0] IDX_RELOAD_LOW = 6'h11;
	localparam logic [ARPT_IDX_W-1:0] IDX_WAVE_OUT_CTRL = 6'h12;
	localparam logic [ARPT_IDX_W-1:0] IDX_CHANNEL_STATUS = 6'h13;
	localparam logic [ARPT_IDX_W-1:0] IDX_DUTY_HIGH = 6'h17;
	localparam logic [ARPT_IDX_W-1:0] IDX_DUTY_LOW = 6'h18;

	// field positions
	localparam int CS_SRC_LSB = 3;
	localparam int CS_OVF_BIT = 2;
	localparam int CS_WRAP_IE_BIT = 1;
	localparam int CS_MATCH_IE_BIT = 0;
	localparam int CH_INVERT_BIT = 1;
	localparam int CH_MATCH_BIT = 0;
	localparam int WOC_OE_BIT = 0;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [ARPT_CNT_W-1:0] CNT_TOP = 12'hFFF;
	localparam logic [ARPT_CNT_W-1:0] DUTY_NONE = 12'h000;

	// timing
	localparam int TB_PERIOD_US = 1000;
	localparam int CLK_FREQ_KHZ = 20000;
	localparam int TB_CYCLES = TB_PERIOD_US * CLK_FREQ_KHZ / 1000;
	localparam int SLOW_DIV = 32;

	typedef enum logic [1:0] {
		SRC_OFF = 2'h0,
		SRC_TIMEBASE = 2'h1,
		SRC_CPU = 2'h2,
		SRC_RSVD = 2'h3
	} arpt_src_t;

	// gray order along run -> wait -> active-halt -> halt
	typedef enum logic [1:0] {
		PWR_RUN = 2'h0,
		PWR_WAIT = 2'h1,
		PWR_ACTIVE_HALT = 2'h3,
		PWR_HALT = 2'h2
	} arpt_pwr_t;

	typedef struct packed {
		logic awvalid;
		logic [ARPT_ADDR_W-1:0] awaddr;
		logic wvalid;
		logic [ARPT_DATA_W-1:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [ARPT_ADDR_W-1:0] araddr;
		logic rready;
	} arpt_axi_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [ARPT_DATA_W-1:0] rdata;
		logic [1:0] rresp;
	} arpt_axi_rsp_t;

endpackage : arpt_pkg

// File: hw/arpt_timer.sv
// The address map and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/10ps

module arpt_timer
	import arpt_pkg::*;
#(
	parameter int P_TB_CYCLES = TB_CYCLES
)
(
	input wire logic i_clk_sys,
	input wire logic i_srst,
	input wire arpt_axi_req_t i_axi,
	input wire arpt_pwr_t i_pwr_mode,
	input wire logic i_slow_mode,
	output arpt_axi_rsp_t o_axi,
	output logic o_wave_pin,
	output logic o_wave_pin_oe_n,
	output logic o_irq_wrap,
	output logic o_irq_match,
	output logic o_wake
);

	localparam int TBW = $clog2(P_TB_CYCLES + 1);
	localparam int SDW = $clog2(SLOW_DIV);
	localparam logic [TBW-1:0] TB_LAST = TBW'(P_TB_CYCLES - 1);
	localparam logic [SDW-1:0] SLOW_LAST = SDW'(SLOW_DIV - 1);

	typedef struct packed {
		arpt_axi_rsp_t rsp;
		logic aw_have;
		logic [ARPT_ADDR_W-1:0] aw_addr;
		logic w_have;
		logic [ARPT_DATA_W-1:0] w_data;
		logic [3:0] w_strb;
		arpt_src_t src;
		logic ovf;
		logic wrap_ie;
		logic match_ie;
		logic [ARPT_CNT_W-1:0] count;
		logic [ARPT_CNT_W-1:0] reload;
		logic wave_oe;
		logic invert;
		logic match_flag;
		logic [ARPT_CNT_W-1:0] duty;
		logic [ARPT_CNT_W-1:0] shadow;
		logic lock;
		logic wave;
		logic pin;
		logic pin_oe_n;
		logic irq_wrap;
		logic irq_match;
		logic wake;
		logic [TBW-1:0] tb_cnt;
		logic [SDW-1:0] slow_cnt;
	} arpt_state_t;

	arpt_state_t state_ff;
	arpt_state_t nxt_state;

	////////////////////////////////////////////////////////////////////////////////
	// register read mux

	function automatic logic [ARPT_DATA_W:0] read_reg(input arpt_state_t s, input logic [ARPT_ADDR_W-1:0] addr);
		logic [7:0] val;
		logic ok;
		// reserved bits and unmapped reads return zero
		val = REG_RESET;
		ok = 1'b1;
		case (addr[ARPT_ADDR_W-1:2])
			IDX_CTRL_STATUS: val = {3'h0, s.src, s.ovf, s.wrap_ie, s.match_ie};
			IDX_COUNT_HIGH: val = {4'h0, s.count[11:8]};
			IDX_COUNT_LOW: val = s.count[7:0];
			IDX_RELOAD_HIGH: val = {4'h0, s.reload[11:8]};
			IDX_RELOAD_LOW: val = s.reload[7:0];
			IDX_WAVE_OUT_CTRL: val = {7'h00, s.wave_oe};
			IDX_CHANNEL_STATUS: val = {6'h00, s.invert, s.match_flag};
			IDX_DUTY_HIGH: val = {4'h0, s.duty[11:8]};
			IDX_DUTY_LOW: val = s.duty[7:0];
			default: ok = 1'b0;
		endcase
		read_reg = {ok, 24'h000000, val};
	endfunction : read_reg

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb
	begin
		logic do_wr;
		logic wr_ok;
		logic [7:0] wb;
		logic [ARPT_DATA_W:0] rd;
		logic tb_tick;
		logic slow_tick;
		logic raw_tick;
		logic run_ok;
		logic tick;
		logic wrapped;
		logic hit;
		logic cmp_live;
		logic [ARPT_CNT_W-1:0] cnt_nxt;
		logic [ARPT_CNT_W-1:0] cmp_val;
		do_wr = 1'b0;
		wr_ok = 1'b0;
		wb = REG_RESET;
		rd = '0;
		tb_tick = 1'b0;
		slow_tick = 1'b0;
		raw_tick = 1'b0;
		run_ok = 1'b0;
		tick = 1'b0;
		wrapped = 1'b0;
		hit = 1'b0;
		cmp_live = 1'b0;
		cnt_nxt = state_ff.count;
		cmp_val = state_ff.duty;
		nxt_state = state_ff;

		// write address and data are taken independently
		if (state_ff.rsp.awready && i_axi.awvalid)
		begin
			nxt_state.aw_have = 1'b1;
			nxt_state.aw_addr = i_axi.awaddr;
		end
		if (state_ff.rsp.wready && i_axi.wvalid)
		begin
			nxt_state.w_have = 1'b1;
			nxt_state.w_data = i_axi.wdata;
			nxt_state.w_strb = i_axi.wstrb;
		end
		if (state_ff.rsp.bvalid && i_axi.bready)
		begin
			nxt_state.rsp.bvalid = 1'b0;
		end
		do_wr = state_ff.aw_have && state_ff.w_have && !state_ff.rsp.bvalid;
		wb = state_ff.w_data[7:0];
		if (do_wr)
		begin
			wr_ok = 1'b1;
			nxt_state.aw_have = 1'b0;
			nxt_state.w_have = 1'b0;
			nxt_state.rsp.bvalid = 1'b1;
			// a write with lane 0 disabled is answered but stores nothing
			if (state_ff.w_strb[0])
			begin
				case (state_ff.aw_addr[ARPT_ADDR_W-1:2])
					IDX_CTRL_STATUS:
					begin
						nxt_state.src = arpt_src_t'(wb[CS_SRC_LSB+:2]);
						nxt_state.wrap_ie = wb[CS_WRAP_IE_BIT];
						nxt_state.match_ie = wb[CS_MATCH_IE_BIT];
					end
					IDX_RELOAD_HIGH:
					begin
						nxt_state.reload[11:8] = wb[3:0];
					end
					IDX_RELOAD_LOW:
					begin
						nxt_state.reload[7:0] = wb;
					end
					IDX_WAVE_OUT_CTRL:
					begin
						// enable hands the pin to the wave
						nxt_state.wave_oe = wb[WOC_OE_BIT];
					end
					IDX_CHANNEL_STATUS:
					begin
						nxt_state.invert = wb[CH_INVERT_BIT];
					end
					IDX_DUTY_HIGH:
					begin
						nxt_state.duty[11:8] = wb[3:0];
						nxt_state.lock = 1'b1;
					end
					IDX_DUTY_LOW:
					begin
						nxt_state.duty[7:0] = wb;
						nxt_state.lock = 1'b0;
					end
					IDX_COUNT_HIGH, IDX_COUNT_LOW:
					begin
						// counter is read only, the write is answered and dropped
						wr_ok = 1'b1;
					end
					default:
					begin
						// unmapped index stores nothing
						wr_ok = 1'b0;
					end
				endcase
			end
			else
			begin
				rd = read_reg(state_ff, state_ff.aw_addr);
				wr_ok = rd[ARPT_DATA_W];
			end
			nxt_state.rsp.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
		end
		// a held address or data waits while the previous response is still pending
		nxt_state.rsp.awready = !nxt_state.aw_have;
		nxt_state.rsp.wready = !nxt_state.w_have;

		// reads answer on the edge that takes the address
		if (state_ff.rsp.rvalid && i_axi.rready)
		begin
			nxt_state.rsp.rvalid = 1'b0;
		end
		if (state_ff.rsp.arready && i_axi.arvalid)
		begin
			rd = read_reg(state_ff, i_axi.araddr);
			nxt_state.rsp.rvalid = 1'b1;
			nxt_state.rsp.rdata = rd[ARPT_DATA_W-1:0];
			nxt_state.rsp.rresp = rd[ARPT_DATA_W] ? RESP_OKAY : RESP_SLVERR;
			// read clears come first so a hardware set later in this cycle wins
			// status read clears overflow flag
			if (i_axi.araddr[ARPT_ADDR_W-1:2] == IDX_CTRL_STATUS)
			begin
				nxt_state.ovf = 1'b0;
			end
			// channel status read clears match flag
			if (i_axi.araddr[ARPT_ADDR_W-1:2] == IDX_CHANNEL_STATUS)
			begin
				nxt_state.match_flag = 1'b0;
			end
		end
		nxt_state.rsp.arready = !nxt_state.rsp.rvalid;

		////////////////////////////////////////////////////////////////////////////
		// tick generation

		// timebase runs from the system clock so slow mode leaves it alone
		tb_tick = (state_ff.tb_cnt == TB_LAST);
		nxt_state.tb_cnt = tb_tick ? '0 : TBW'(state_ff.tb_cnt + 1'b1);
		// slow mode divides cpu clock by 32
		slow_tick = (state_ff.slow_cnt == SLOW_LAST);
		nxt_state.slow_cnt = SDW'(state_ff.slow_cnt + 1'b1);
		case (state_ff.src)
			SRC_TIMEBASE: raw_tick = tb_tick;
			SRC_CPU: raw_tick = i_slow_mode ? slow_tick : 1'b1;
			default: raw_tick = 1'b0;
		endcase
		case (i_pwr_mode)
			PWR_RUN, PWR_WAIT: run_ok = 1'b1;
			// active-halt keeps timebase with wrap enable
			PWR_ACTIVE_HALT: run_ok = (state_ff.src == SRC_TIMEBASE) && state_ff.wrap_ie;
			default: run_ok = 1'b0;
		endcase
		tick = raw_tick && run_ok;

		////////////////////////////////////////////////////////////////////////////
		// counter, compare and wave

		if (tick)
		begin
			// overflow flag lasts one counter tick
			nxt_state.ovf = 1'b0;
			wrapped = (state_ff.count == CNT_TOP);
			if (wrapped)
			begin
				// reload gives 4096 minus reload period
				cnt_nxt = state_ff.reload;
				nxt_state.ovf = 1'b1;
				// shadow copied even when half written
				nxt_state.shadow = state_ff.duty;
				if (state_ff.wave_oe)
				begin
					nxt_state.wave = 1'b1;
				end
			end
			else
			begin
				cnt_nxt = ARPT_CNT_W'(state_ff.count + 1'b1);
			end
			nxt_state.count = cnt_nxt;
			// modulation uses shadow, compare mode uses duty
			// compare mode sees written duty at once
			cmp_val = state_ff.wave_oe ? nxt_state.shadow : state_ff.duty;
			cmp_live = !state_ff.lock && (state_ff.wave_oe || state_ff.duty != DUTY_NONE);
			hit = cmp_live && (cnt_nxt == cmp_val);
			if (hit)
			begin
				// match sets flag, wins over read clear
				nxt_state.match_flag = 1'b1;
				if (state_ff.wave_oe)
				begin
					nxt_state.wave = 1'b0;
				end
			end
		end

		// released pin is held low so no stale level lingers on the pad side
		// pin driven only while enabled
		nxt_state.pin_oe_n = !nxt_state.wave_oe;
		nxt_state.pin = nxt_state.wave_oe && (nxt_state.wave ^ nxt_state.invert);

		nxt_state.irq_wrap = nxt_state.ovf && nxt_state.wrap_ie;
		nxt_state.irq_match = nxt_state.match_flag && nxt_state.match_ie;
		// wake from wait on either, active-halt on wrap only
		case (i_pwr_mode)
			PWR_WAIT: nxt_state.wake = nxt_state.irq_wrap || nxt_state.irq_match;
			PWR_ACTIVE_HALT: nxt_state.wake = nxt_state.irq_wrap && (nxt_state.src == SRC_TIMEBASE);
			default: nxt_state.wake = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge i_clk_sys)
	begin
		// reset clears counter and all control
		if (i_srst)
		begin
			state_ff <= '0;
		end
		else
		begin
			state_ff <= nxt_state;
		end
	end

	// outputs are plain flop bits, no logic after the register
	assign o_axi = state_ff.rsp;
	assign o_wave_pin = state_ff.pin;
	assign o_wave_pin_oe_n = state_ff.pin_oe_n;
	assign o_irq_wrap = state_ff.irq_wrap;
	assign o_irq_match = state_ff.irq_match;
	assign o_wake = state_ff.wake;

endmodule : arpt_timer

// File: dv/arpt_timer_checker.sv
`timescale 1ns/10ps
module arpt_timer_checker
	import arpt_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_srst,
	input wire arpt_axi_req_t i_axi,
	input wire arpt_pwr_t i_pwr_mode,
	input wire logic i_slow_mode,
	input wire arpt_axi_rsp_t o_axi,
	input wire logic o_wave_pin,
	input wire logic o_wave_pin_oe_n,
	input wire logic o_irq_wrap,
	input wire logic o_irq_match,
	input wire logic o_wake
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_srst);
	////////////////////////////////////////////////////////////////
	// released pin idle
	property p_pin_off; o_wave_pin_oe_n |-> !o_wave_pin; endproperty
	a_pin_off: assert property (p_pin_off) else $error("pin high while released");
	property p_wake_wait; $past(i_pwr_mode) == PWR_WAIT |-> o_wake == (o_irq_wrap || o_irq_match); endproperty
	a_wake_wait: assert property (p_wake_wait) else $error("wake wrong in wait");
	property p_wake_none; ($past(i_pwr_mode) == PWR_HALT || $past(i_pwr_mode) == PWR_RUN) |-> !o_wake; endproperty
	a_wake_none: assert property (p_wake_none) else $error("wake in run or halt");
	property p_wake_ah; $past(i_pwr_mode) == PWR_ACTIVE_HALT && !o_irq_wrap |-> !o_wake; endproperty
	a_wake_ah: assert property (p_wake_ah) else $error("wake without wrap");
	property p_b_hold; o_axi.bvalid && !i_axi.bready |=> o_axi.bvalid && $stable(o_axi.bresp); endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
	property p_r_hold; o_axi.rvalid && !i_axi.rready |=> o_axi.rvalid && $stable(o_axi.rdata); endproperty
	a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
	property p_r_lat; i_axi.arvalid && o_axi.arready |=> o_axi.rvalid; endproperty
	a_r_lat: assert property (p_r_lat) else $error("read answer late");
	property p_w_lat; i_axi.awvalid && o_axi.awready && i_axi.wvalid && o_axi.wready |-> ##2 o_axi.bvalid; endproperty
	a_w_lat: assert property (p_w_lat) else $error("write answer late");
endmodule : arpt_timer_checker

// File: dv/arpt_timer_test.sv
`timescale 1ns/10ps
module arpt_timer_test;
	import arpt_pkg::*;
	logic clk = 1'b0;
	logic srst = 1'b1;
	arpt_axi_req_t req = '0;
	arpt_axi_rsp_t rsp;
	arpt_pwr_t pwr = PWR_RUN;
	logic slow = 1'b0;
	logic pin, oe_n, irq_w, irq_m, wake;
	logic [1:0] rr, br;
	logic [31:0] a, b;
	int errors = 0;
	int checked = 0;
	int cyc = 0;
	int hi, per;
	logic [5:0] regs [9] = '{IDX_CTRL_STATUS, IDX_COUNT_HIGH, IDX_COUNT_LOW, IDX_RELOAD_HIGH, IDX_RELOAD_LOW,
		IDX_WAVE_OUT_CTRL, IDX_CHANNEL_STATUS, IDX_DUTY_HIGH, IDX_DUTY_LOW};
	always #25 clk = ~clk;
	arpt_timer #(.P_TB_CYCLES(8)) arpt_timer_i (.i_clk_sys(clk), .i_srst(srst), .i_axi(req),
		.i_pwr_mode(pwr), .i_slow_mode(slow), .o_axi(rsp), .o_wave_pin(pin), .o_wave_pin_oe_n(oe_n),
		.o_irq_wrap(irq_w), .o_irq_match(irq_m), .o_wake(wake));
	////////////////////////////////////////////////////////////////
	task tally_and_finish;
		if (errors == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : tally_and_finish
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			errors++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task wr(input logic [5:0] i, input logic [7:0] d);
		logic aw, w;
		@(posedge clk);
		req.awvalid <= 1'b1;
		req.awaddr <= {i, 2'h0};
		req.wvalid <= 1'b1;
		req.wdata <= {24'h0, d};
		req.wstrb <= 4'hF;
		req.bready <= 1'b1;
		aw = 1'b0;
		w = 1'b0;
		do
		begin
			@(posedge clk);
			if (req.awvalid && rsp.awready)
			begin
				aw = 1'b1;
				req.awvalid <= 1'b0;
			end
			if (req.wvalid && rsp.wready)
			begin
				w = 1'b1;
				req.wvalid <= 1'b0;
			end
		end while (!(aw && w));
		do @(posedge clk); while (rsp.bvalid !== 1'b1);
		br = rsp.bresp;
		req.bready <= 1'b0;
	endtask : wr
	task rd(input logic [5:0] i, output logic [31:0] d);
		@(posedge clk);
		req.arvalid <= 1'b1;
		req.araddr <= {i, 2'h0};
		req.rready <= 1'b1;
		do @(posedge clk); while (rsp.arready !== 1'b1);
		req.arvalid <= 1'b0;
		do @(posedge clk); while (rsp.rvalid !== 1'b1);
		d = rsp.rdata;
		rr = rsp.rresp;
		req.rready <= 1'b0;
	endtask : rd
	// rise to fall and rise to rise of the pin, in clocks
	task meas;
		while (pin !== 1'b0)
			@(posedge clk);
		while (pin !== 1'b1)
			@(posedge clk);
		hi = 0;
		per = 0;
		while (pin === 1'b1)
		begin
			@(posedge clk);
			hi++;
			per++;
		end
		while (pin === 1'b0)
		begin
			@(posedge clk);
			per++;
		end
	endtask : meas
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			errors++;
			tally_and_finish();
		end
	end
	////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		foreach (regs[k])
		begin
			rd(regs[k], a);
			chk("reset value", 32'h0, a);
		end
		rd(6'h3F, a);
		chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, rr});
		wr(6'h3F, 8'h55);
		chk("unmapped write resp", {30'h0, RESP_SLVERR}, {30'h0, br});
		// compare mode matches long before the first overflow loads the shadow
		wr(IDX_DUTY_HIGH, 8'h00);
		wr(IDX_DUTY_LOW, 8'h10);
		wr(IDX_CTRL_STATUS, 8'h11);
		repeat (40) @(posedge clk);
		chk("match before wrap", 1, irq_m);
		wr(IDX_CTRL_STATUS, 8'hE3);
		chk("write resp", {30'h0, RESP_OKAY}, {30'h0, br});
		rd(IDX_CTRL_STATUS, a);
		chk("ctrl readback", 32'h03, a);
		// pwm with reload FFA and duty FFC
		wr(IDX_RELOAD_HIGH, 8'h0F);
		wr(IDX_RELOAD_LOW, 8'hFA);
		wr(IDX_DUTY_HIGH, 8'h0F);
		wr(IDX_DUTY_LOW, 8'hFC);
		wr(IDX_WAVE_OUT_CTRL, 8'h01);
		wr(IDX_CTRL_STATUS, 8'h10);
		meas();
		chk("high time", 2, hi);
		chk("period", 6, per);
		chk("pin enabled", 0, oe_n);
		wr(IDX_CHANNEL_STATUS, 8'h02);
		meas();
		chk("inverted high", 4, hi);
		wr(IDX_CHANNEL_STATUS, 8'h00);
		slow <= 1'b1;
		meas();
		chk("slow high", 64, hi);
		chk("slow period", 192, per);
		slow <= 1'b0;
		foreach (regs[k])
		begin
			if (k < 2)
			begin
				pwr <= k ? PWR_ACTIVE_HALT : PWR_HALT;
				rd(IDX_COUNT_LOW, a);
				repeat (10) @(posedge clk);
				rd(IDX_COUNT_LOW, b);
				chk("count frozen", a, b);
			end
		end
		// count is frozen between FFA and FFF, so the high byte is known
		rd(IDX_COUNT_LOW, a);
		rd(IDX_COUNT_HIGH, b);
		chk("count high", 32'h0F, b);
		wr(IDX_WAVE_OUT_CTRL, 8'h00);
		chk("pin released", 1, oe_n);
		pwr <= PWR_WAIT;
		wr(IDX_CTRL_STATUS, 8'h12);
		while (irq_w !== 1'b1)
			@(posedge clk);
		chk("wake in wait", 1, wake);
		@(posedge clk);
		chk("overflow width", 0, irq_w);
		pwr <= PWR_RUN;
		// compare mode, locked until the low byte lands
		wr(IDX_CTRL_STATUS, 8'h01);
		wr(IDX_RELOAD_LOW, 8'hF0);
		wr(IDX_DUTY_HIGH, 8'h0F);
		rd(IDX_CHANNEL_STATUS, a);
		wr(IDX_CTRL_STATUS, 8'h11);
		repeat (40) @(posedge clk);
		chk("locked match", 0, irq_m);
		wr(IDX_DUTY_LOW, 8'hF8);
		repeat (40) @(posedge clk);
		chk("match irq", 1, irq_m);
		wr(IDX_CTRL_STATUS, 8'h01);
		rd(IDX_CHANNEL_STATUS, a);
		chk("match flag", 32'h01, a);
		rd(IDX_CHANNEL_STATUS, a);
		chk("match cleared", 32'h00, a);
		wr(IDX_RELOAD_HIGH, 8'h00);
		wr(IDX_RELOAD_LOW, 8'h00);
		wr(IDX_DUTY_HIGH, 8'h00);
		wr(IDX_DUTY_LOW, 8'h00);
		rd(IDX_CHANNEL_STATUS, a);
		wr(IDX_CTRL_STATUS, 8'h11);
		repeat (4300) @(posedge clk);
		chk("zero duty match", 0, irq_m);
		wr(IDX_CTRL_STATUS, 8'h0A);
		pwr <= PWR_ACTIVE_HALT;
		rd(IDX_COUNT_LOW, a);
		repeat (30) @(posedge clk);
		rd(IDX_COUNT_LOW, b);
		chk("timebase runs", 1, a != b);
		tally_and_finish();
	end
endmodule : arpt_timer_test
bind arpt_timer arpt_timer_checker arpt_timer_checker_i (.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_axi(i_axi),
	.i_pwr_mode(i_pwr_mode), .i_slow_mode(i_slow_mode), .o_axi(o_axi), .o_wave_pin(o_wave_pin),
	.o_wave_pin_oe_n(o_wave_pin_oe_n), .o_irq_wrap(o_irq_wrap), .o_irq_match(o_irq_match), .o_wake(o_wake));
